// >>> pkg/nibble_add_regs.vh
/*
  Register offsets, field positions, reset values and sizes for the nibble
  add datapath. Definitions only; included by the design files.
*/
`ifndef NIBBLE_ADD_REGS_VH
`define NIBBLE_ADD_REGS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_INDEX      8'h00
`define OFS_FLAGS      8'h04
`define OFS_GRPTR      8'h08
`define OFS_DMBANK     8'h0C
`define OFS_CMD        8'h10
`define OFS_STATUS     8'h14
`define OFS_MEMADDR    8'h18
`define OFS_MEMDATA    8'h1C

// ****************************************************************
// Field positions
// ****************************************************************
`define FLG_CARRY      0
`define FLG_ZERO       1
`define FLG_COMPARE    2
`define FLG_DECIMAL    3
`define FLG_IDXEN      4
`define IX_MPE         11
`define CMD_COL_LO     0
`define CMD_ROW_LO     4
`define CMD_ARG_LO     7
`define CMD_KIND_LO    12

// ****************************************************************
// Operation kinds
// ****************************************************************
`define KIND_ADD_RM    2'h0
`define KIND_ADD_MI    2'h1
`define KIND_ADD_WITH_CARRY_RM   2'h2

// ****************************************************************
// Sizes and reset values
// ****************************************************************
`define DM_AW          11
`define DM_DEPTH       2048
`define INDEX_RST      12'h000
`define FLAGS_RST      5'h00
`define DEC_LIMIT      5'h09
`define DEC_ADJUST     5'h06

`endif

// >>> core/nibble_data_mem.v
/*
  Nibble-wide data memory, one port, registered read data.
  Assumes one access per cycle from its owner; a write also returns the
  written value on the read port next cycle.
*/
`timescale 1ns/1ns
`include "nibble_add_regs.vh"

module nibble_data_mem (
  // Clock and reset
  input  wire                 clk,
  input  wire                 rst_n,
  // Access port
  input  wire                 we,
  input  wire [`DM_AW-1:0]    addr,
  input  wire [3:0]           wd,
  output reg  [3:0]           rd_r
);

  reg [3:0] mem [0:`DM_DEPTH-1];

  // Write, and register the read word
  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wd;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_r <= 4'h0;
    end else if (we) begin
      rd_r <= wd;
    end else begin
      rd_r <= mem[addr];
    end
  end

endmodule // nibble_data_mem

// >>> core/nibble_add_with_index_addressing.v
/*
  Nibble add datapath: register-plus-memory add, memory-plus-immediate add
  and add with carry, compare-only mode, carry/zero flags, binary or decimal
  digits, and index-pointer ORing onto the operand address.
  Assumes a register bus master that reads data one cycle after the strobe
  and a software-run sequence; operations run one at a time.
*/
// Implementation choices: the strobed register port and the register addresses.
// Operation
// - Register-plus-memory add stores the sum into the general register when compare is clear.
// - Memory-plus-immediate add stores the sum back into the same memory nibble when compare is clear.
// - With compare set no destination is written; only carry, zero and the status result change.
// - Carry is set on a nibble overflow, or in decimal on a digit above nine, and cleared otherwise, compare set or not.
// - A nonzero result always clears the zero flag.
// - A zero result with compare clear sets the zero flag.
// - A zero result with compare set leaves the zero flag as it was.
// - The decimal flag chooses binary or decimal adds.
// - Add with carry adds memory nibble and carry into the general register.
// - With index enable set the memory address is the operand address ORed with the index pointer.
// - The index pointer is three nibbles: enable and bank, row, column.
// - With the pointer enable bit clear the memory pointer is not offered for indirect moves.
// - The register operand takes only its column; bank and row come from the register pointer.
`timescale 1ns/1ns
`include "nibble_add_regs.vh"

module nibble_add_with_index_addressing (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Register bus
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata_r,
  // Status pins
  output reg         busy_r,
  output reg         mem_ptr_enable_r
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [2:0] S_IDLE  = 3'd0;
  localparam [2:0] S_ISSUE = 3'd1;
  localparam [2:0] S_RDM   = 3'd2;
  localparam [2:0] S_RDR   = 3'd3;
  localparam [2:0] S_EXEC  = 3'd4;
  localparam [2:0] S_PEEK  = 3'd5;
  localparam [2:0] S_PCAP  = 3'd6;

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Digit add: returns {carry, nibble}; decimal adjust above nine
  function [4:0] nib_add;
    input [3:0] a;
    input [3:0] b;
    input       cin;
    input       dec;
    reg   [4:0] s;
    begin
      s = {1'b0, a} + {1'b0, b} + {4'h0, cin};
      if (dec && (s > `DEC_LIMIT)) begin
        s = s + `DEC_ADJUST;
        nib_add = {1'b1, s[3:0]};
      end else begin
        nib_add = s;
      end
    end
  endfunction

  // Bus offset match, used by every write decode
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg  [11:0]        index_pointer_r;
  reg                carry_flag_r;
  reg                zero_flag_r;
  reg                compare_flag_r;
  reg                decimal_flag_r;
  reg                index_enable_r;
  reg  [5:0]         grptr_r;          // [5:3] bank, [2:0] row
  reg  [2:0]         dmbank_r;
  reg  [13:0]        cmd_r;
  reg  [3:0]         result_r;
  reg  [`DM_AW-1:0]  eff_addr_r;
  reg  [`DM_AW-1:0]  memaddr_r;
  reg  [3:0]         peek_r;
  reg  [3:0]         m_val_r;
  reg  [2:0]         state_r;
  reg  [2:0]         state_nxt;

  wire [1:0]         kind     = cmd_r[`CMD_KIND_LO+1:`CMD_KIND_LO];
  wire [3:0]         m_col    = cmd_r[`CMD_COL_LO+3:`CMD_COL_LO];
  wire [2:0]         m_row    = cmd_r[`CMD_ROW_LO+2:`CMD_ROW_LO];
  wire [3:0]         arg      = cmd_r[`CMD_ARG_LO+3:`CMD_ARG_LO];
  wire               reg_form = (kind != `KIND_ADD_MI);

  // ****************************************************************
  // Address forming
  // ****************************************************************
  // Index pointer nibbles: high = enable + bank, middle = row, low = column
  wire [3:0] index_high_nibble   = index_pointer_r[11:8];
  wire [3:0] index_middle_nibble = index_pointer_r[7:4];
  wire [3:0] index_low_nibble    = index_pointer_r[3:0];
  wire [`DM_AW-1:0] ix_addr = {index_high_nibble[2:0], index_middle_nibble,
                               index_low_nibble};
  wire [`DM_AW-1:0] op_addr = {dmbank_r, 1'b0, m_row, m_col};
  // Enable bit is not an address bit, so it never leaks into the OR
  wire [`DM_AW-1:0] eff_m   = index_enable_r ? (op_addr | ix_addr) : op_addr;
  // General register: pointer gives bank and row, operand gives column
  wire [`DM_AW-1:0] gr_addr = {grptr_r[5:3], 1'b0, grptr_r[2:0], arg};

  // ****************************************************************
  // Adder
  // ****************************************************************
  wire [3:0] mem_q;
  wire [3:0] op_a   = reg_form ? mem_q : m_val_r;
  wire [3:0] op_b   = reg_form ? m_val_r : arg;
  wire       op_cin = (kind == `KIND_ADD_WITH_CARRY_RM) ? carry_flag_r : 1'b0;
  wire [4:0] sum    = nib_add(op_a, op_b, op_cin, decimal_flag_r);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire wr_index   = wr && hit(addr, `OFS_INDEX);
  wire wr_flags   = wr && hit(addr, `OFS_FLAGS);
  wire wr_grptr   = wr && hit(addr, `OFS_GRPTR);
  wire wr_dmbank  = wr && hit(addr, `OFS_DMBANK);
  wire wr_cmd     = wr && hit(addr, `OFS_CMD);
  wire wr_memaddr = wr && hit(addr, `OFS_MEMADDR);
  wire wr_memdata = wr && hit(addr, `OFS_MEMDATA);
  wire idle       = (state_r == S_IDLE);

  // ****************************************************************
  // Sequencer and memory port
  // ****************************************************************
  reg              mem_we;
  reg [`DM_AW-1:0] mem_addr;
  reg [3:0]        mem_wd;

  // Single memory port: the sequencer owns it, bus pokes only when idle
  always @* begin
    state_nxt = state_r;
    mem_we    = 1'b0;
    mem_addr  = memaddr_r;
    mem_wd    = wdata[3:0];
    case (state_r)
      S_IDLE: begin
        if (wr_cmd) begin
          state_nxt = S_ISSUE;
        end else if (wr_memaddr) begin
          state_nxt = S_PEEK;
        end else if (wr_memdata) begin
          mem_we = 1'b1;
        end
      end
      S_ISSUE: begin
        mem_addr  = eff_m;
        state_nxt = S_RDM;
      end
      S_RDM: begin
        mem_addr  = gr_addr;
        state_nxt = reg_form ? S_RDR : S_EXEC;
      end
      S_RDR: begin
        mem_addr  = gr_addr;
        state_nxt = S_EXEC;
      end
      S_EXEC: begin
        mem_addr  = reg_form ? gr_addr : eff_addr_r;
        mem_wd    = sum[3:0];
        mem_we    = !compare_flag_r;
        state_nxt = S_IDLE;
      end
      S_PEEK: begin
        state_nxt = S_PCAP;
      end
      S_PCAP: begin
        state_nxt = S_IDLE;
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  nibble_data_mem u_mem (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (mem_we),
    .addr  (mem_addr),
    .wd    (mem_wd),
    .rd_r  (mem_q)
  );

  // State, command latch and operand capture
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= S_IDLE;
      cmd_r      <= 14'h0000;
      m_val_r    <= 4'h0;
      eff_addr_r <= {`DM_AW{1'b0}};
      result_r   <= 4'h0;
      busy_r     <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r  <= (state_nxt != S_IDLE);
      if (idle && wr_cmd) begin
        cmd_r <= wdata[13:0];
      end
      if (state_r == S_ISSUE) begin
        eff_addr_r <= eff_m;
      end
      if (state_r == S_RDM) begin
        m_val_r <= mem_q;
      end
      if (state_r == S_EXEC) begin
        result_r <= sum[3:0];
      end
    end
  end

  // ****************************************************************
  // Flags and software registers
  // ****************************************************************
  // An add in its final cycle wins over a bus write of carry or zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      carry_flag_r   <= 1'b0;
      zero_flag_r    <= 1'b0;
      compare_flag_r <= 1'b0;
      decimal_flag_r <= 1'b0;
      index_enable_r <= 1'b0;
    end else begin
      if (wr_flags) begin
        carry_flag_r   <= wdata[`FLG_CARRY];
        zero_flag_r    <= wdata[`FLG_ZERO];
        compare_flag_r <= wdata[`FLG_COMPARE];
        decimal_flag_r <= wdata[`FLG_DECIMAL];
        index_enable_r <= wdata[`FLG_IDXEN];
      end
      if (state_r == S_EXEC) begin
        carry_flag_r <= sum[4];
        if (sum[3:0] != 4'h0) begin
          zero_flag_r <= 1'b0;
        end else if (!compare_flag_r) begin
          zero_flag_r <= 1'b1;
        end else begin
          zero_flag_r <= zero_flag_r;
        end
      end
    end
  end

  // Pointers, memory window and the pointer-enable pin
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      index_pointer_r  <= `INDEX_RST;
      grptr_r          <= 6'h00;
      dmbank_r         <= 3'h0;
      memaddr_r        <= {`DM_AW{1'b0}};
      peek_r           <= 4'h0;
      mem_ptr_enable_r <= 1'b0;
    end else begin
      if (wr_index) begin
        index_pointer_r <= wdata[11:0];
      end
      mem_ptr_enable_r <= index_pointer_r[`IX_MPE];
      if (wr_grptr) begin
        grptr_r <= wdata[5:0];
      end
      if (wr_dmbank) begin
        dmbank_r <= wdata[2:0];
      end
      if (idle && wr_memaddr) begin
        memaddr_r <= wdata[`DM_AW-1:0];
      end
      if (idle && wr_memdata) begin
        peek_r <= wdata[3:0];
      end else if (state_r == S_PCAP) begin
        peek_r <= mem_q;
      end
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  reg [31:0] rd_mux;

  // Unmapped and write-only offsets read as zero
  always @* begin
    rd_mux = 32'h0000_0000;
    case (addr)
      `OFS_INDEX:   rd_mux = {20'h0_0000, index_pointer_r};
      `OFS_FLAGS:   rd_mux = {27'h000_0000, index_enable_r, decimal_flag_r,
                              compare_flag_r, zero_flag_r, carry_flag_r};
      `OFS_GRPTR:   rd_mux = {26'h000_0000, grptr_r};
      `OFS_DMBANK:  rd_mux = {29'h0000_0000, dmbank_r};
      `OFS_STATUS:  rd_mux = {13'h0000, eff_addr_r, result_r, 3'h0, busy_r};
      `OFS_MEMADDR: rd_mux = {21'h00_0000, memaddr_r};
      `OFS_MEMDATA: rd_mux = {28'h000_0000, peek_r};
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

endmodule // nibble_add_with_index_addressing

// >>> dv/nibble_add_checker.sv
/* Assertion checker for the nibble add datapath.
   Assumes the shared register map and one bus strobe per cycle. */
`timescale 1ns/1ns
`include "nibble_add_regs.vh"

module nibble_add_checker (
  // Clock and reset
  input wire        clk,
  input wire        rst_n,
  // Register bus
  input wire [7:0]  addr,
  input wire [31:0] wdata,
  input wire        wr,
  input wire        rd,
  input wire [31:0] rdata_r,
  // Status pins
  input wire        busy_r,
  input wire        mem_ptr_enable_r
);
  // ************
  // Address shadow
  // ************
  reg  [11:0] idx_r;
  reg  [2:0]  bank_r;
  reg         idxen_r;
  reg  [10:0] ea_r;
  reg         seen_r;
  wire        cmd_go;
  assign cmd_go = wr && addr == `OFS_CMD && !busy_r;

  // A peek reuses the address path, so the last address is trusted only until one
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_r <= 12'h000;
      bank_r <= 3'h0;
      idxen_r <= 1'b0;
      ea_r <= 11'h000;
      seen_r <= 1'b0;
    end else begin
      if (wr && addr == `OFS_INDEX) idx_r <= wdata[11:0];
      if (wr && addr == `OFS_DMBANK) bank_r <= wdata[2:0];
      if (wr && addr == `OFS_FLAGS) idxen_r <= wdata[`FLG_IDXEN];
      if (wr && addr == `OFS_MEMADDR) seen_r <= 1'b0;
      if (cmd_go) ea_r <= {bank_r, 1'b0, wdata[6:0]} | (idxen_r ? idx_r[10:0] : 11'h000);
      if (cmd_go) seen_r <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Busy spans of the two operation shapes: the immediate form is issue,
  // operand read and execute; the register forms add one more read
  sequence s_busy3;
    busy_r[*3] ##1 !busy_r;
  endsequence
  sequence s_busy4;
    busy_r[*4] ##1 !busy_r;
  endsequence

  property p_busy_mi;
    cmd_go && wdata[13:12] == `KIND_ADD_MI |=> s_busy3;
  endproperty
  a_busy_mi: assert property (p_busy_mi)
    else $error("immediate add busy span wrong");
  property p_busy_rm;
    cmd_go && wdata[13:12] != `KIND_ADD_MI |=> s_busy4;
  endproperty
  a_busy_rm: assert property (p_busy_rm)
    else $error("register add busy span wrong");
  property p_ea;
    rd && addr == `OFS_STATUS && !busy_r && seen_r |=> rdata_r[18:8] == ea_r;
  endproperty
  a_ea: assert property (p_ea)
    else $error("effective address wrong");
  property p_mpe;
    wr && addr == `OFS_INDEX |-> ##2 mem_ptr_enable_r == $past(wdata[`IX_MPE], 2);
  endproperty
  a_mpe: assert property (p_mpe)
    else $error("pointer enable pin wrong");
  property p_ix_width;
    rd && addr == `OFS_INDEX |=> rdata_r == {20'h0_0000, idx_r};
  endproperty
  a_ix_width: assert property (p_ix_width)
    else $error("index readback wrong");
  property p_rd_idle;
    !rd |=> rdata_r == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  property p_unmapped;
    rd && addr >= 8'h20 |=> rdata_r == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_stat_busy;
    rd && addr == `OFS_STATUS |=> rdata_r[0] == $past(busy_r);
  endproperty
  a_stat_busy: assert property (p_stat_busy)
    else $error("status busy bit wrong");
endmodule // nibble_add_checker

bind nibble_add_with_index_addressing nibble_add_checker u_chk (.clk(clk), .rst_n(rst_n),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r), .busy_r(busy_r),
  .mem_ptr_enable_r(mem_ptr_enable_r));

// >>> dv/add_ref_model.sv
/* Reference arithmetic of the decoder side for one nibble add.
   Assumes the caller has already fetched both operands. */
`timescale 1ns/1ns

module add_ref_model;
  // Predict result, carry and zero of one add
  task predict(input [3:0] a, input [3:0] b, input cin, input dec, input cmp,
               input zin, output [3:0] res, output cy, output z);
    reg [4:0] sum;
    begin
      sum = {1'b0, a} + {1'b0, b} + {4'h0, cin};
      cy = sum[4];
      if (dec && sum > 5'h09) begin
        sum = sum + 5'h06;
        cy = 1'b1;
      end
      res = sum[3:0];
      z = (res != 4'h0) ? 1'b0 : (cmp ? zin : 1'b1);
    end
  endtask
endmodule // add_ref_model

// >>> dv/tb_nibble_add_with_index_addressing.sv
/* Self-checking bench for the nibble add datapath.
   Assumes the shared register map and add_ref_model arithmetic. */
`timescale 1ns/1ns
`include "nibble_add_regs.vh"

module tb_nibble_add_with_index_addressing;
  reg         clk;
  reg         rst_n;
  reg  [7:0]  addr;
  reg  [31:0] wdata;
  reg         wr;
  reg         rd;
  wire [31:0] rdata_r;
  wire        busy_r;
  wire        mem_ptr_enable_r;
  integer     failures;
  integer     checks_done;
  reg  [31:0] rv;

  nibble_add_with_index_addressing dut (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r), .busy_r(busy_r),
    .mem_ptr_enable_r(mem_ptr_enable_r));
  add_ref_model u_ref ();

  // ************
  // Bus tasks
  // ************
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
        $display("Run complete: PASS");
      end else begin
        $display("Run complete: FAIL");
      end
      $finish;
    end
  endtask
  // Strobes drop on the edge that takes them, one gap before the next
  task bus_wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task bus_rd(input [7:0] a);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 rv = rdata_r;
    end
  endtask
  // Bounded poll; a hang ends the run as a failure
  task wait_idle;
    integer n;
    begin
      n = 0;
      @(posedge clk);
      #1;
      while (busy_r !== 1'b0 && n < 20) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      if (busy_r !== 1'b0) begin
        failures = failures + 1;
        wrap_up;
      end
    end
  endtask
  task set_mem(input [10:0] a, input [3:0] d);
    begin
      bus_wr(`OFS_MEMADDR, {21'h00_0000, a});
      wait_idle;
      bus_wr(`OFS_MEMDATA, {28'h000_0000, d});
    end
  endtask
  task get_mem(input [10:0] a);
    begin
      bus_wr(`OFS_MEMADDR, {21'h00_0000, a});
      wait_idle;
      bus_rd(`OFS_MEMDATA);
    end
  endtask
  // One add: f = {index enable, decimal, compare, zero, carry}; data bank is 1
  task run(input [1:0] k, input [4:0] f, input [11:0] ix, input [5:0] gp,
           input [6:0] mrc, input [3:0] ri, input [3:0] mv, input [3:0] rgv);
    reg [10:0] ea;
    reg [10:0] ra;
    reg [3:0]  res;
    reg [3:0]  dexp;
    reg        cy;
    reg        z;
    begin
      ea = {3'h1, 1'b0, mrc} | (f[4] ? ix[10:0] : 11'h000);
      ra = {gp[5:3], 1'b0, gp[2:0], ri};
      set_mem(ea, mv);
      if (k != `KIND_ADD_MI) set_mem(ra, rgv);
      bus_wr(`OFS_INDEX, {20'h0_0000, ix});
      bus_wr(`OFS_GRPTR, {26'h000_0000, gp});
      bus_wr(`OFS_FLAGS, {27'h000_0000, f});
      bus_wr(`OFS_CMD, {18'h0_0000, k, 1'b0, ri, mrc});
      wait_idle;
      u_ref.predict(mv, (k == `KIND_ADD_MI) ? ri : rgv, (k == `KIND_ADD_WITH_CARRY_RM) & f[0],
                    f[3], f[2], f[1], res, cy, z);
      dexp = f[2] ? ((k == `KIND_ADD_MI) ? mv : rgv) : res;
      bus_rd(`OFS_STATUS);
      chk(rv & 32'h0007_FFF0, {13'h0000, ea, res, 4'h0});
      bus_rd(`OFS_FLAGS);
      chk(rv, {27'h000_0000, f[4:2], z, cy});
      get_mem((k == `KIND_ADD_MI) ? ea : ra);
      chk(rv, {28'h000_0000, dexp});
      chk({31'h0000_0000, mem_ptr_enable_r}, {31'h0000_0000, ix[11]});
      $display("test done: kind %0d flags %h", k, f);
    end
  endtask

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Watchdog sized well beyond the longest expected sequence
  initial begin
    repeat (5000) @(posedge clk);
    failures = failures + 1;
    wrap_up;
  end

  // ************
  // Main sequence
  // ************
  initial begin
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    failures = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    bus_rd(`OFS_INDEX);
    chk(rv, {20'h0_0000, `INDEX_RST});
    bus_rd(`OFS_FLAGS);
    chk(rv, {27'h000_0000, `FLAGS_RST});
    bus_rd(8'h20);
    chk(rv, 32'h0000_0000);
    bus_wr(`OFS_DMBANK, 32'h0000_0001);
    bus_rd(`OFS_DMBANK);
    chk(rv & 32'h0000_0007, 32'h0000_0001);
    $display("test done: reset values");
    // Binary, compare, carry-in, decimal and indexed cases
    run(2'h0, 5'h00, 12'h000, 6'h02, 7'h2F, 4'h3, 4'h3, 4'h4);
    run(2'h0, 5'h01, 12'h000, 6'h02, 7'h2F, 4'h3, 4'h8, 4'h8);
    run(2'h1, 5'h02, 12'h000, 6'h00, 7'h2F, 4'h5, 4'hF, 4'h0);
    run(2'h1, 5'h06, 12'h000, 6'h00, 7'h2F, 4'h8, 4'h8, 4'h0);
    run(2'h1, 5'h04, 12'h000, 6'h00, 7'h2F, 4'h8, 4'h8, 4'h0);
    run(2'h0, 5'h06, 12'h000, 6'h02, 7'h2F, 4'h3, 4'h1, 4'h2);
    run(2'h2, 5'h01, 12'h000, 6'h02, 7'h2F, 4'h3, 4'h7, 4'h8);
    run(2'h2, 5'h05, 12'h000, 6'h02, 7'h2F, 4'h3, 4'h2, 4'h3);
    // Spare kind code runs as a register add and ignores the carry flag
    run(2'h3, 5'h01, 12'h000, 6'h02, 7'h2F, 4'h3, 4'h6, 4'h5);
    run(2'h0, 5'h08, 12'h000, 6'h02, 7'h2F, 4'h3, 4'h5, 4'h7);
    run(2'h1, 5'h08, 12'h000, 6'h00, 7'h2F, 4'h5, 4'h4, 4'h0);
    run(2'h2, 5'h09, 12'h000, 6'h02, 7'h2F, 4'h3, 4'h9, 4'h9);
    run(2'h1, 5'h10, 12'h040, 6'h00, 7'h2F, 4'h5, 4'h2, 4'h0);
    run(2'h0, 5'h10, 12'hA10, 6'h0A, 7'h2F, 4'h3, 4'h3, 4'h4);
    wrap_up;
  end
endmodule // tb_nibble_add_with_index_addressing
